//--- verilog/ict_core.sv
// instruction cycle sequencer with program counter, stack and register state
`timescale 1ns/1ps
module ict_core
    import ict_pkg::*;
#(
    parameter int STACK_DEPTH = 8 // return address slots
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire ict_pkg::ict_instr_t i_instr,
    input wire logic [ict_pkg::DW-1:0] i_mem_rdata,
    input wire logic [ict_pkg::TBL_W-1:0] i_tbl_data,
    output logic [ict_pkg::PC_W-1:0] o_pc,
    output logic [ict_pkg::DW-1:0] o_accum,
    output logic o_carry,
    output logic o_zero,
    output ict_pkg::ict_mem_wr_t o_mem_wr,
    output logic [ict_pkg::PC_W-1:0] o_tbl_addr,
    output logic [ict_pkg::DW-1:0] o_tbl_high,
    output logic o_icyc,
    output logic o_done
);
    import ict_pkg::*;

    localparam int SPW = $clog2(STACK_DEPTH); // stack pointer width

    //////////////////////////////////////////////////////////////////////////
    // declarations
    logic [1:0] phase; // system clock position inside the instruction cycle
    logic cyc_en; // last clock of an instruction cycle
    ict_state_t state; // first or extra cycle of an instruction
    ict_op_t cur_op; // class of the instruction in its extra cycle
    logic [DW-1:0] cur_addr; // its data operand address
    logic [PC_W-1:0] stack [STACK_DEPTH]; // return addresses
    logic [SPW-1:0] sp; // next free stack slot
    logic [PC_W-1:0] stack_top; // most recent return address
    logic [DW-1:0] alu_res;
    logic alu_wr_accum;
    logic alu_wr_mem;
    logic alu_carry;
    logic alu_carry_upd;
    logic alu_zero_upd;
    logic alu_skip;
    logic pc_low_wr; // data write lands on the pc low byte
    logic is_ctrl; // two-cycle control transfer class
    logic need_extra; // instruction takes a second cycle
    logic first_cyc; // closing edge of an instruction's first cycle
    logic [PC_W-1:0] next_pc;

    assign cyc_en = (phase == PH_LAST);
    assign first_cyc = cyc_en && state == ST_EXEC;
    assign stack_top = stack[sp - 1'b1];

    //////////////////////////////////////////////////////////////////////////
    // datapath
    ict_alu u_alu (
        .i_op(i_instr.op),
        .i_to_accum(i_instr.to_accum),
        .i_accum(o_accum),
        .i_mem(i_mem_rdata),
        .i_imm(i_instr.imm),
        .i_bit_sel(i_instr.bit_sel),
        .i_carry(o_carry),
        .o_res(alu_res),
        .o_wr_accum(alu_wr_accum),
        .o_wr_mem(alu_wr_mem),
        .o_carry(alu_carry),
        .o_carry_upd(alu_carry_upd),
        .o_zero_upd(alu_zero_upd),
        .o_skip(alu_skip)
    );

    //////////////////////////////////////////////////////////////////////////
    // next program counter and cycle count of the current instruction
    always_comb begin
        pc_low_wr = alu_wr_mem && i_instr.addr == PC_LOW_ADDR;
        is_ctrl = i_instr.op inside {OP_JUMP, OP_CALL, OP_SUB_RETURN, OP_INT_RETURN,
                                     OP_TABLE_READ};
        need_extra = is_ctrl || pc_low_wr || alu_skip;
        if (i_instr.op == OP_JUMP || i_instr.op == OP_CALL) begin
            next_pc = i_instr.target;
        end else if (i_instr.op == OP_SUB_RETURN || i_instr.op == OP_INT_RETURN) begin
            next_pc = stack_top;
        end else if (pc_low_wr) begin
            next_pc = {o_pc[PC_W-1:DW], alu_res};
        end else if (alu_skip) begin
            next_pc = o_pc + PC_SKIP_STEP;
        end else begin
            next_pc = o_pc + PC_STEP;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // four-clock instruction cycle divider
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            phase <= 2'h0;
            o_icyc <= 1'b0;
        end else begin
            phase <= cyc_en ? 2'h0 : phase + 2'h1;
            o_icyc <= cyc_en;
        end
    end

    // first/extra cycle sequencing and completion pulse
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_EXEC;
            cur_op <= OP_NOP;
            cur_addr <= BYTE_ZERO;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (first_cyc) begin
                cur_op <= i_instr.op;
                cur_addr <= i_instr.addr;
                if (need_extra) begin
                    state <= ST_EXTRA;
                end else begin
                    o_done <= 1'b1;
                end
            end else if (cyc_en) begin
                state <= ST_EXEC;
                o_done <= 1'b1;
            end
        end
    end

    // program counter and stack pointer; jumps leave the stack alone
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pc <= PC_RESET;
            sp <= '0;
        end else if (first_cyc) begin
            o_pc <= next_pc;
            if (i_instr.op == OP_CALL) begin
                sp <= sp + 1'b1;
            end else if (i_instr.op == OP_SUB_RETURN || i_instr.op == OP_INT_RETURN) begin
                sp <= sp - 1'b1;
            end
        end
    end

    // return address storage, no reset needed
    always_ff @(posedge i_clk) begin
        if (first_cyc && i_instr.op == OP_CALL) begin
            stack[sp] <= o_pc + PC_STEP;
        end
    end

    // accumulator and status flags
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_accum <= BYTE_ZERO;
            o_carry <= 1'b0;
            o_zero <= 1'b0;
        end else if (first_cyc) begin
            if (alu_wr_accum) begin
                o_accum <= alu_res;
            end
            if (alu_carry_upd) begin
                o_carry <= alu_carry;
            end
            if (alu_zero_upd) begin
                o_zero <= (alu_res == BYTE_ZERO);
            end
        end
    end

    // data memory write strobe, one clock wide
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mem_wr <= '0;
        end else begin
            o_mem_wr.we <= 1'b0;
            if (first_cyc && alu_wr_mem) begin
                o_mem_wr <= '{we: 1'b1, addr: i_instr.addr, data: alu_res};
            end else if (cyc_en && state == ST_EXTRA && cur_op == OP_TABLE_READ) begin
                o_mem_wr <= '{we: 1'b1, addr: cur_addr, data: i_tbl_data[DW-1:0]};
            end
        end
    end

    // table address out in the first cycle, high byte back in the second
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tbl_addr <= PC_RESET;
            o_tbl_high <= BYTE_ZERO;
        end else if (first_cyc && i_instr.op == OP_TABLE_READ) begin
            o_tbl_addr <= i_instr.target;
        end else if (cyc_en && state == ST_EXTRA && cur_op == OP_TABLE_READ) begin
            o_tbl_high <= i_tbl_data[TBL_W-1:DW];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    a_cycle_four_clocks: assert property (@(posedge i_clk) disable iff (i_rst)
        cyc_en |=> !cyc_en [*3] ##1 cyc_en)
        else $error("instruction cycle is not four clocks");

    a_plain_one_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
        first_cyc && i_instr.op inside {OP_MOVE_M2A, OP_MOVE_I2A, OP_ADD_IMM, OP_NOP}
        |=> o_done && state == ST_EXEC)
        else $error("plain instruction did not finish in one cycle");

    a_ctrl_two_cycles: assert property (@(posedge i_clk) disable iff (i_rst)
        first_cyc && i_instr.op inside {OP_JUMP, OP_CALL, OP_TABLE_READ}
        |=> !o_done && state == ST_EXTRA ##4 o_done)
        else $error("jump, call or table read not two cycles");

    a_return_resumes: assert property (@(posedge i_clk) disable iff (i_rst)
        first_cyc && i_instr.op inside {OP_SUB_RETURN, OP_INT_RETURN}
        |=> o_pc == $past(stack_top) && !o_done ##4 o_done)
        else $error("return wrong address or cycle count");

    a_pc_low_jump: assert property (@(posedge i_clk) disable iff (i_rst)
        first_cyc && alu_wr_mem && i_instr.addr == PC_LOW_ADDR
        |=> o_pc[DW-1:0] == $past(alu_res) && state == ST_EXTRA)
        else $error("pc low write did not jump with extra cycle");

    a_skip_timing: assert property (@(posedge i_clk) disable iff (i_rst)
        first_cyc && alu_skip && !pc_low_wr
        |=> o_pc == $past(o_pc) + PC_SKIP_STEP && !o_done ##4 o_done)
        else $error("taken skip wrong address or cycle count");

    a_call_saves: assert property (@(posedge i_clk) disable iff (i_rst)
        first_cyc && i_instr.op == OP_CALL
        |=> stack_top == $past(o_pc) + PC_STEP && o_pc == $past(i_instr.target))
        else $error("call did not save the return point");

    a_add_carry: assert property (@(posedge i_clk) disable iff (i_rst)
        first_cyc && i_instr.op == OP_ADD
        |=> o_carry == ($past(o_accum) + $past(i_mem_rdata) > 255))
        else $error("add carry wrong");

    a_logic_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        first_cyc && i_instr.op inside {OP_AND, OP_OR, OP_XOR, OP_COMPL}
        |=> o_zero == ($past(alu_res) == BYTE_ZERO))
        else $error("logic zero flag wrong");

    a_bit_only: assert property (@(posedge i_clk) disable iff (i_rst)
        first_cyc && i_instr.op == OP_BIT_SET
        |=> o_mem_wr.we
            && o_mem_wr.data == ($past(i_mem_rdata) | (BIT_ONE << $past(i_instr.bit_sel))))
        else $error("bit set changed other bits");

    a_jump_no_push: assert property (@(posedge i_clk) disable iff (i_rst)
        first_cyc && i_instr.op == OP_JUMP |=> sp == $past(sp) && o_pc == $past(i_instr.target))
        else $error("jump touched the stack");
endmodule // ict_core

//--- inc/ict_pkg.sv
// shared types and constants for the instruction cycle timing core
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - one instruction cycle equals four system clocks
// - ordinary instructions finish in one cycle
// - jump, call, table read take two cycles
// - subroutine and interrupt returns take two cycles
// - program counter low write jumps, adds cycle
// - taken skip adds one cycle, otherwise one
// - conditional branches test byte or bit, skip
// - call saves return point, return resumes after
// - moves: memory/accumulator both ways, immediate to accumulator
// - add carries above 255, subtract borrows below 0
// - increment/decrement by one into memory or accumulator
// - logic results of zero set zero flag
// - rotate one bit, carry variants through carry
// - bit set/clear touches only addressed bit
// - table read returns program memory data
//////////////////////////////////////////////////////////////////////////////
package ict_pkg;
    localparam int PHASES = 4;                  // system clocks per instruction cycle
    localparam logic [1:0] PH_LAST = 2'h3;      // phase that closes an instruction cycle
    localparam int CLK_PERIOD_NS = 5;           // system clock period
    localparam int ICYC_NS = PHASES * CLK_PERIOD_NS; // instruction cycle length
    localparam int DW = 8;                      // data width
    localparam int PC_W = 11;                   // program counter width
    localparam int TBL_W = 16;                  // program memory word width
    localparam logic [DW-1:0] PC_LOW_ADDR = 8'h06; // data address of the pc low byte
    localparam logic [PC_W-1:0] PC_STEP = 11'h001; // advance to next instruction
    localparam logic [PC_W-1:0] PC_SKIP_STEP = 11'h002; // step over one instruction
    localparam logic [PC_W-1:0] PC_RESET = 11'h000; // program counter after reset
    localparam logic [DW-1:0] BYTE_ZERO = 8'h00; // data reset value
    localparam logic [DW-1:0] BIT_ONE = 8'h01;  // mask seed for bit operations
    localparam logic [DW-1:0] BYTE_ONE = 8'h01; // increment/decrement step

    // operation classes
    typedef enum logic [4:0] {
        OP_NOP, OP_MOVE_M2A, OP_MOVE_A2M, OP_MOVE_I2A,
        OP_ADD, OP_SUB, OP_ADD_IMM, OP_SUB_IMM, OP_INC, OP_DEC,
        OP_AND, OP_OR, OP_XOR, OP_COMPL,
        OP_ROT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT_C, OP_ROT_LEFT_C,
        OP_BIT_SET, OP_BIT_CLEAR,
        OP_SKIP_ZERO, OP_SKIP_BIT_ZERO, OP_SKIP_BIT_SET, OP_SKIP_INC_ZERO, OP_SKIP_DEC_ZERO,
        OP_JUMP, OP_CALL, OP_SUB_RETURN, OP_INT_RETURN, OP_TABLE_READ
    } ict_op_t;

    // one decoded instruction
    typedef struct packed {
        ict_op_t op;                // operation class
        logic to_accum;             // result into accumulator instead of memory
        logic [DW-1:0] addr;        // data memory operand address
        logic [DW-1:0] imm;         // immediate data
        logic [2:0] bit_sel;        // bit index for bit operations
        logic [PC_W-1:0] target;    // jump/call target or table address
    } ict_instr_t;

    // data memory write strobe with address and data
    typedef struct packed {
        logic we;
        logic [DW-1:0] addr;
        logic [DW-1:0] data;
    } ict_mem_wr_t;

    // execution state
    typedef enum logic {ST_EXEC, ST_EXTRA} ict_state_t;
endpackage

//--- verilog/ict_alu.sv
// combinational datapath for the data operation classes
`timescale 1ns/1ps
module ict_alu
    import ict_pkg::*;
(
    input wire ict_pkg::ict_op_t i_op,
    input wire logic i_to_accum,
    input wire logic [ict_pkg::DW-1:0] i_accum,
    input wire logic [ict_pkg::DW-1:0] i_mem,
    input wire logic [ict_pkg::DW-1:0] i_imm,
    input wire logic [2:0] i_bit_sel,
    input wire logic i_carry,
    output logic [ict_pkg::DW-1:0] o_res,
    output logic o_wr_accum,
    output logic o_wr_mem,
    output logic o_carry,
    output logic o_carry_upd,
    output logic o_zero_upd,
    output logic o_skip
);
    import ict_pkg::*;

    logic [DW:0] wide; // nine-bit sum or difference
    logic [DW-1:0] mask; // one-hot mask of the addressed bit

    // result, destination and flag updates per class
    always_comb begin
        wide = '0;
        mask = BIT_ONE << i_bit_sel;
        o_res = BYTE_ZERO;
        o_wr_accum = 1'b0;
        o_wr_mem = 1'b0;
        o_carry = i_carry;
        o_carry_upd = 1'b0;
        o_zero_upd = 1'b0;
        o_skip = 1'b0;
        unique case (i_op)
            // transfers leave flags alone
            OP_MOVE_M2A: begin o_res = i_mem; o_wr_accum = 1'b1; end
            OP_MOVE_A2M: begin o_res = i_accum; o_wr_mem = 1'b1; end
            OP_MOVE_I2A: begin o_res = i_imm; o_wr_accum = 1'b1; end
            // ninth bit is carry on add, borrow on subtract
            OP_ADD, OP_ADD_IMM, OP_SUB, OP_SUB_IMM: begin
                if (i_op == OP_ADD || i_op == OP_ADD_IMM) begin
                    wide = {1'b0, i_accum} + {1'b0, (i_op == OP_ADD) ? i_mem : i_imm};
                end else begin
                    wide = {1'b0, i_accum} - {1'b0, (i_op == OP_SUB) ? i_mem : i_imm};
                end
                o_res = wide[DW-1:0];
                o_carry = wide[DW];
                o_carry_upd = 1'b1;
                o_zero_upd = 1'b1;
                o_wr_accum = i_to_accum || i_op == OP_ADD_IMM || i_op == OP_SUB_IMM;
                o_wr_mem = !o_wr_accum;
            end
            // step by exactly one
            OP_INC, OP_DEC: begin
                o_res = (i_op == OP_INC) ? i_mem + BYTE_ONE : i_mem - BYTE_ONE;
                o_zero_upd = 1'b1;
                o_wr_accum = i_to_accum;
                o_wr_mem = !i_to_accum;
            end
            // logic operations update only the zero flag
            OP_AND, OP_OR, OP_XOR, OP_COMPL: begin
                unique case (i_op)
                    OP_AND: o_res = i_accum & i_mem;
                    OP_OR: o_res = i_accum | i_mem;
                    OP_XOR: o_res = i_accum ^ i_mem;
                    default: o_res = ~i_mem;
                endcase
                o_zero_upd = 1'b1;
                o_wr_accum = i_to_accum;
                o_wr_mem = !i_to_accum;
            end
            // plain rotates keep carry, carry rotates pass through it
            OP_ROT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT_C, OP_ROT_LEFT_C: begin
                unique case (i_op)
                    OP_ROT_RIGHT: o_res = {i_mem[0], i_mem[DW-1:1]};
                    OP_ROT_LEFT: o_res = {i_mem[DW-2:0], i_mem[DW-1]};
                    OP_ROT_RIGHT_C: begin
                        o_res = {i_carry, i_mem[DW-1:1]};
                        o_carry = i_mem[0];
                        o_carry_upd = 1'b1;
                    end
                    default: begin
                        o_res = {i_mem[DW-2:0], i_carry};
                        o_carry = i_mem[DW-1];
                        o_carry_upd = 1'b1;
                    end
                endcase
                o_wr_accum = i_to_accum;
                o_wr_mem = !i_to_accum;
            end
            // read-modify-write of a single bit
            OP_BIT_SET: begin o_res = i_mem | mask; o_wr_mem = 1'b1; end
            OP_BIT_CLEAR: begin o_res = i_mem & ~mask; o_wr_mem = 1'b1; end
            // byte and bit tests; the zero test may copy the byte to the accumulator
            OP_SKIP_ZERO: begin
                o_res = i_mem;
                o_wr_accum = i_to_accum;
                o_skip = (i_mem == BYTE_ZERO);
            end
            OP_SKIP_BIT_ZERO: o_skip = !(|(i_mem & mask));
            OP_SKIP_BIT_SET: o_skip = |(i_mem & mask);
            OP_SKIP_INC_ZERO, OP_SKIP_DEC_ZERO: begin
                o_res = (i_op == OP_SKIP_INC_ZERO) ? i_mem + BYTE_ONE : i_mem - BYTE_ONE;
                o_wr_accum = i_to_accum;
                o_wr_mem = !i_to_accum;
                o_skip = (o_res == BYTE_ZERO);
            end
            // control transfer classes carry no data result
            OP_NOP, OP_JUMP, OP_CALL, OP_SUB_RETURN, OP_INT_RETURN, OP_TABLE_READ: begin
            end
        endcase
    end
endmodule // ict_alu

//--- verif/instruction_cycle_timing_tb_top.sv
// self-checking testbench for the instruction cycle timing core
`timescale 1ns/1ps
module instruction_cycle_timing_tb_top;
    import ict_pkg::*;
    logic i_clk = 1'b0; // system clock
    logic i_rst = 1'b1; // async reset, active high
    ict_instr_t i_instr = '0; // decoded instruction at o_pc
    logic [DW-1:0] i_mem_rdata = 8'h00; // operand byte
    logic [TBL_W-1:0] i_tbl_data = 16'h0000; // program memory word
    logic [PC_W-1:0] o_pc;
    logic [DW-1:0] o_accum;
    logic o_carry;
    logic o_zero;
    ict_mem_wr_t o_mem_wr;
    logic [PC_W-1:0] o_tbl_addr;
    logic [DW-1:0] o_tbl_high;
    logic o_icyc;
    logic o_done;
    int fails = 0; // mismatches seen
    int tests_run = 0; // comparisons made
    // expected machine state
    logic [PC_W-1:0] e_pc = PC_RESET;
    logic [DW-1:0] e_accum = 8'h00;
    logic e_c = 1'b0;
    logic e_z = 1'b0;
    logic e_we;
    logic [DW-1:0] e_wa;
    logic [DW-1:0] e_wd;
    int e_cyc;
    logic [PC_W-1:0] stk[$]; // expected return addresses
    bit first = 1'b1; // first instruction has no prior completion to time from
    ict_instr_t ins;
    logic [63:0] rv;

    always #2.5 i_clk = ~i_clk;

    ict_core #(.STACK_DEPTH(8)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_instr(i_instr),
        .i_mem_rdata(i_mem_rdata), .i_tbl_data(i_tbl_data), .o_pc(o_pc), .o_accum(o_accum),
        .o_carry(o_carry), .o_zero(o_zero), .o_mem_wr(o_mem_wr), .o_tbl_addr(o_tbl_addr),
        .o_tbl_high(o_tbl_high), .o_icyc(o_icyc), .o_done(o_done));

    //////////////////////////////////////////////////////////////////////////////
    // reference model: advances the expected state by one instruction
    function automatic void predict(ict_instr_t x, logic [DW-1:0] m, logic [TBL_W-1:0] t);
        logic [DW:0] w;
        logic [DW-1:0] b;
        logic [DW-1:0] r;
        logic wa;
        logic wm;
        logic sk;
        logic br;
        b = (x.op inside {OP_ADD_IMM, OP_SUB_IMM}) ? x.imm : m;
        r = m;
        wa = x.to_accum; // most classes pick their destination
        wm = !x.to_accum;
        sk = 1'b0;
        br = 1'b0;
        e_cyc = 1;
        e_we = 1'b0;
        case (x.op)
            OP_MOVE_M2A: wa = 1'b1;
            OP_MOVE_A2M: r = e_accum;
            OP_MOVE_I2A: r = x.imm;
            OP_ADD, OP_ADD_IMM, OP_SUB, OP_SUB_IMM: begin
                w = (x.op inside {OP_ADD, OP_ADD_IMM}) ? {1'b0, e_accum} + {1'b0, b}
                                                       : {1'b0, e_accum} - {1'b0, b};
                r = w[DW-1:0];
                e_c = w[DW]; // carry above 255, borrow below 0
                e_z = (r == BYTE_ZERO);
            end
            OP_INC, OP_DEC, OP_AND, OP_OR, OP_XOR, OP_COMPL: begin
                case (x.op)
                    OP_INC: r = m + BYTE_ONE;
                    OP_DEC: r = m - BYTE_ONE;
                    OP_AND: r = e_accum & m;
                    OP_OR: r = e_accum | m;
                    OP_XOR: r = e_accum ^ m;
                    default: r = ~m;
                endcase
                e_z = (r == BYTE_ZERO);
            end
            OP_ROT_RIGHT: r = {m[0], m[7:1]};
            OP_ROT_LEFT: r = {m[6:0], m[7]};
            OP_ROT_RIGHT_C: begin
                r = {e_c, m[7:1]};
                e_c = m[0];
            end
            OP_ROT_LEFT_C: begin
                r = {m[6:0], e_c};
                e_c = m[7];
            end
            OP_BIT_SET: r = m | (BIT_ONE << x.bit_sel);
            OP_BIT_CLEAR: r = m & ~(BIT_ONE << x.bit_sel);
            OP_SKIP_ZERO: begin
                sk = (m == BYTE_ZERO);
                wm = 1'b0;
            end
            OP_SKIP_INC_ZERO, OP_SKIP_DEC_ZERO: begin
                r = (x.op == OP_SKIP_INC_ZERO) ? m + BYTE_ONE : m - BYTE_ONE;
                sk = (r == BYTE_ZERO);
            end
            OP_SKIP_BIT_ZERO, OP_SKIP_BIT_SET: sk = (m[x.bit_sel] == (x.op == OP_SKIP_BIT_SET));
            OP_TABLE_READ: r = t[7:0];
            default: ; // control transfers and idle
        endcase
        if (x.op inside {OP_MOVE_A2M, OP_BIT_SET, OP_BIT_CLEAR, OP_TABLE_READ}) begin
            wa = 1'b0;
            wm = 1'b1;
        end
        if (x.op inside {OP_MOVE_M2A, OP_MOVE_I2A, OP_ADD_IMM, OP_SUB_IMM}) begin
            wa = 1'b1;
            wm = 1'b0;
        end
        if (x.op inside {OP_NOP, OP_SKIP_BIT_ZERO, OP_SKIP_BIT_SET, OP_JUMP, OP_CALL,
                         OP_SUB_RETURN, OP_INT_RETURN}) begin
            wa = 1'b0;
            wm = 1'b0;
        end
        if (x.op == OP_CALL) begin
            stk.push_back(e_pc + PC_STEP); // return point is the next address
        end
        if (x.op inside {OP_JUMP, OP_CALL, OP_SUB_RETURN, OP_INT_RETURN, OP_TABLE_READ}) begin
            e_cyc = 2;
        end
        if (x.op inside {OP_JUMP, OP_CALL}) begin
            e_pc = x.target;
            br = 1'b1;
        end else if (x.op inside {OP_SUB_RETURN, OP_INT_RETURN}) begin
            e_pc = stk.pop_back();
            br = 1'b1;
        end
        if (wa) e_accum = r;
        if (wm && x.addr == PC_LOW_ADDR) begin
            e_pc = {e_pc[PC_W-1:DW], r}; // low byte write redirects the flow
            e_cyc = 2;
        end else if (!br) begin
            e_pc = e_pc + (sk ? PC_SKIP_STEP : PC_STEP);
            e_cyc = sk ? 2 : 1;
            if (x.op == OP_TABLE_READ) e_cyc = 2;
        end
        // a pc low write still strobes the data write port
        if (wm) begin
            e_we = 1'b1;
            e_wa = x.addr;
            e_wd = r;
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////////
    // one comparison with counting
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (exp !== got) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // prints the counts and the verdict, then ends the run
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // issues one instruction and checks timing and results at completion
    task automatic run_op(ict_instr_t x, logic [DW-1:0] m, logic [TBL_W-1:0] t);
        int n;
        int ic;
        logic we;
        logic [DW-1:0] wa;
        logic [DW-1:0] wd;
        n = 0;
        ic = 0;
        we = 1'b0;
        wa = '0;
        wd = '0;
        i_instr <= x;
        i_mem_rdata <= m;
        i_tbl_data <= t;
        predict(x, m, t);
        do begin
            @(posedge i_clk);
            n++;
            if (o_icyc === 1'b1) ic++;
            if (o_mem_wr.we === 1'b1) begin
                we = 1'b1;
                wa = o_mem_wr.addr;
                wd = o_mem_wr.data;
            end
        end while (o_done !== 1'b1 && n < 64);
        if (n >= 64) begin
            check("done", 1, 0);
            report_and_stop();
        end
        if (!first) begin
            check("clocks", 4 * e_cyc, n);
            check("icyc", e_cyc, ic);
        end
        first = 1'b0;
        check("pc", e_pc, o_pc);
        check("accum", e_accum, o_accum);
        check("carry", e_c, o_carry);
        check("zero", e_z, o_zero);
        check("we", e_we, we);
        if (e_we) check("wr", {e_wa, e_wd}, {wa, wd});
        if (x.op == OP_TABLE_READ) begin
            check("tbl", {x.target, t[15:8]}, {o_tbl_addr, o_tbl_high});
        end
    endtask

    // builds an instruction from its fields
    function automatic ict_instr_t mk(ict_op_t op, logic ta, logic [DW-1:0] ad, logic [DW-1:0] im,
                                      logic [2:0] bs, logic [PC_W-1:0] tg);
        mk = '{op: op, to_accum: ta, addr: ad, imm: im, bit_sel: bs, target: tg};
    endfunction

    //////////////////////////////////////////////////////////////////////////////
    // main sequence: reset, corner cases, then random traffic
    initial begin
        void'($urandom(32'he164));
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        run_op(mk(OP_MOVE_I2A, 1'b1, 8'h20, 8'hff, 3'h0, 11'h000), 8'h00, 16'h0000);
        run_op(mk(OP_ADD, 1'b1, 8'h21, 8'h00, 3'h0, 11'h000), 8'h01, 16'h0000);
        run_op(mk(OP_SUB_IMM, 1'b1, 8'h21, 8'h01, 3'h0, 11'h000), 8'h00, 16'h0000);
        run_op(mk(OP_AND, 1'b1, 8'h22, 8'h00, 3'h0, 11'h000), 8'h00, 16'h0000);
        run_op(mk(OP_CALL, 1'b0, 8'h22, 8'h00, 3'h0, 11'h123), 8'h00, 16'h0000);
        run_op(mk(OP_SUB_RETURN, 1'b0, 8'h22, 8'h00, 3'h0, 11'h000), 8'h00, 16'h0000);
        run_op(mk(OP_CALL, 1'b0, 8'h22, 8'h00, 3'h0, 11'h456), 8'h00, 16'h0000);
        run_op(mk(OP_INT_RETURN, 1'b0, 8'h22, 8'h00, 3'h0, 11'h000), 8'h00, 16'h0000);
        run_op(mk(OP_JUMP, 1'b0, 8'h22, 8'h00, 3'h0, 11'h7f0), 8'h00, 16'h0000);
        run_op(mk(OP_SKIP_ZERO, 1'b1, 8'h23, 8'h00, 3'h0, 11'h000), 8'h00, 16'h0000);
        run_op(mk(OP_SKIP_ZERO, 1'b0, 8'h23, 8'h00, 3'h0, 11'h000), 8'h05, 16'h0000);
        run_op(mk(OP_SKIP_DEC_ZERO, 1'b0, 8'h24, 8'h00, 3'h0, 11'h000), 8'h01, 16'h0000);
        run_op(mk(OP_MOVE_A2M, 1'b0, PC_LOW_ADDR, 8'h00, 3'h0, 11'h000), 8'h00, 16'h0000);
        run_op(mk(OP_BIT_CLEAR, 1'b0, 8'h25, 8'h00, 3'h7, 11'h000), 8'hff, 16'h0000);
        run_op(mk(OP_TABLE_READ, 1'b0, 8'h26, 8'h00, 3'h0, 11'h3a5), 8'h00, 16'hbeef);
        run_op(mk(OP_ROT_LEFT_C, 1'b1, 8'h27, 8'h00, 3'h0, 11'h000), 8'h80, 16'h0000);
        $display("test corner cases done");
        for (int k = 0; k < 600; k++) begin
            rv = {$urandom(), $urandom()};
            ins = rv[35:0];
            ins.op = ict_op_t'($urandom_range(0, 29));
            if (ins.addr == PC_LOW_ADDR) ins.addr = 8'h30; // keep random data writes off the pc low byte
            if (ins.op inside {OP_SUB_RETURN, OP_INT_RETURN} && stk.size() == 0) ins.op = OP_CALL;
            if (ins.op == OP_CALL && stk.size() >= 7) ins.op = OP_NOP; // stay inside the stack
            run_op(ins, DW'($urandom()), TBL_W'($urandom()));
        end
        $display("test random traffic done");
        report_and_stop();
    end
endmodule // instruction_cycle_timing_tb_top
